// File: core/sr_latch_defines.svh
// How it works
// - Latch follows set/reset input levels, sampled on sys_clk edges
// - All set and reset inputs active high
// - Set and reset together: reset wins
// - Sources: comparators, interrupt pin, divided clock
// - Firmware pulse bits self clear after one write
// - Firmware pulse bits always read zero
// - Enables: set in 7..4, reset in 3..0
// - Disabled source has no effect on latch
// - Divider field: divide by 4 up to 512
// - Pin carries latch only when enabled and selected
// - True output has priority over inverted output
// - Pin driven only when direction bit clear
// - Device reset leaves latch state uninitialised
`ifndef SR_LATCH_DEFINES_SVH
`define SR_LATCH_DEFINES_SVH

// ****************************************************************
// Register map
// ****************************************************************
`define ADDR_LATCH_CONTROL 4'h0
`define ADDR_LATCH_SOURCE_ENABLES 4'h1
`define ADDR_LATCH_STATUS 4'h2

// ****************************************************************
// Field positions
// ****************************************************************
`define CTRL_FW_RESET_BIT 0
`define CTRL_FW_SET_BIT 1
`define CTRL_NQ_EN_BIT 2
`define CTRL_Q_EN_BIT 3
`define CTRL_DIV_LSB 4
`define CTRL_EN_BIT 7
`define SRC_RESET_LSB 0
`define SRC_SET_LSB 4

// ****************************************************************
// Reset values
// ****************************************************************
`define LATCH_CONTROL_RESET 8'h00
`define LATCH_SOURCE_ENABLES_RESET 8'h00

// ****************************************************************
// Timing
// ****************************************************************
`define DIV_BASE_LOG2 1
`define DIV_CNT_WIDTH 9

`endif

// File: core/sr_latch_pkg.sv
package sr_latch_pkg;

  // Control register layout, msb first
  typedef struct packed {
    logic latch_enable;
    logic [2:0] latch_clock_divider;
    logic true_output_pin_enable;
    logic inverted_output_pin_enable;
    logic firmware_set_pulse;
    logic firmware_reset_pulse;
  } latch_control_t;

  // One group of four source enables, msb first
  typedef struct packed {
    logic pin_enable;
    logic clock_enable;
    logic comp_two_enable;
    logic comp_one_enable;
  } source_group_t;

  typedef struct packed {
    source_group_t set_group;
    source_group_t reset_group;
  } latch_source_enables_t;

endpackage : sr_latch_pkg

// File: core/set_reset_latch_unit.sv
`timescale 1ns/1ps
`default_nettype none
`include "sr_latch_defines.svh"

module set_reset_latch_unit
(
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,

  // Register port
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  output logic [7:0] reg_rdata,

  // Asynchronous sources
  input wire logic [1:0] comparator_output,
  input wire logic external_interrupt_pin,

  // Port pin
  input wire logic port_direction_bit,
  input wire logic port_data,
  output logic latch_output_pin_o,
  output logic latch_output_pin_oe,

  // Internal latch outputs
  output logic latch_q,
  output logic latch_qn
);

  // ****************************************************************
  // Synchronisers
  // ****************************************************************
  logic [2:0] sync1_q;
  logic [2:0] sync2_q;
  logic [2:0] sync1_d;
  logic [2:0] sync2_d;

  always_comb
  begin
    sync1_d = {external_interrupt_pin, comparator_output};
    sync2_d = sync1_q;
  end

  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      sync1_q <= 3'h0;
      sync2_q <= 3'h0;
    end
    else
    begin
      sync1_q <= sync1_d;
      sync2_q <= sync2_d;
    end
  end

  // ****************************************************************
  // Registers
  // ****************************************************************
  sr_latch_pkg::latch_control_t ctrl_q;
  sr_latch_pkg::latch_control_t ctrl_d;
  sr_latch_pkg::latch_source_enables_t src_en_q;
  sr_latch_pkg::latch_source_enables_t src_en_d;
  logic [7:0] rdata_q;
  logic [7:0] rdata_d;
  logic fw_set_q;
  logic fw_set_d;
  logic fw_reset_q;
  logic fw_reset_d;
  logic state_q;

  always_comb
  begin
    ctrl_d = ctrl_q;
    src_en_d = src_en_q;
    fw_set_d = 1'b0;
    fw_reset_d = 1'b0;
    rdata_d = 8'h00;
    if (reg_write)
    begin
      if (reg_addr == `ADDR_LATCH_CONTROL)
      begin
        ctrl_d = sr_latch_pkg::latch_control_t'(reg_wdata);
        // Pulse bits are never stored
        ctrl_d.firmware_set_pulse = 1'b0;
        ctrl_d.firmware_reset_pulse = 1'b0;
        fw_set_d = reg_wdata[`CTRL_FW_SET_BIT];
        fw_reset_d = reg_wdata[`CTRL_FW_RESET_BIT];
      end
      else if (reg_addr == `ADDR_LATCH_SOURCE_ENABLES)
      begin
        src_en_d = sr_latch_pkg::latch_source_enables_t'(reg_wdata);
      end
    end
    if (reg_read)
    begin
      if (reg_addr == `ADDR_LATCH_CONTROL)
      begin
        // Stored pulse bits are zero, so reads return zero
        rdata_d = 8'(ctrl_q);
      end
      else if (reg_addr == `ADDR_LATCH_SOURCE_ENABLES)
      begin
        rdata_d = 8'(src_en_q);
      end
      else if (reg_addr == `ADDR_LATCH_STATUS)
      begin
        rdata_d = {7'h00, state_q};
      end
      else
      begin
        rdata_d = 8'h00;
      end
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      ctrl_q <= sr_latch_pkg::latch_control_t'(`LATCH_CONTROL_RESET);
      src_en_q <= sr_latch_pkg::latch_source_enables_t'(`LATCH_SOURCE_ENABLES_RESET);
      rdata_q <= 8'h00;
      fw_set_q <= 1'b0;
      fw_reset_q <= 1'b0;
    end
    else
    begin
      ctrl_q <= ctrl_d;
      src_en_q <= src_en_d;
      rdata_q <= rdata_d;
      fw_set_q <= fw_set_d;
      fw_reset_q <= fw_reset_d;
    end
  end

  // ****************************************************************
  // Clock divider
  // ****************************************************************
  logic [`DIV_CNT_WIDTH-1:0] div_cnt_q;
  logic [`DIV_CNT_WIDTH-1:0] div_cnt_d;
  logic div_clk;

  always_comb
  begin
    div_cnt_d = div_cnt_q + `DIV_CNT_WIDTH'(1);
    // Bit k of a free counter toggles with period 2^(k+1)
    // Index is four bits wide so the slowest step reaches the top counter bit
    div_clk = div_cnt_q[{1'b0, ctrl_q.latch_clock_divider} + 4'(`DIV_BASE_LOG2)];
  end

  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      div_cnt_q <= `DIV_CNT_WIDTH'(0);
    end
    else
    begin
      div_cnt_q <= div_cnt_d;
    end
  end

  // ****************************************************************
  // Latch core
  // ****************************************************************
  logic set_any;
  logic reset_any;
  logic state_d;

  always_comb
  begin
    set_any = fw_set_q
      | (src_en_q.set_group.pin_enable & sync2_q[2])
      | (src_en_q.set_group.clock_enable & div_clk)
      | (src_en_q.set_group.comp_two_enable & sync2_q[1])
      | (src_en_q.set_group.comp_one_enable & sync2_q[0]);
    reset_any = fw_reset_q
      | (src_en_q.reset_group.pin_enable & sync2_q[2])
      | (src_en_q.reset_group.clock_enable & div_clk)
      | (src_en_q.reset_group.comp_two_enable & sync2_q[1])
      | (src_en_q.reset_group.comp_one_enable & sync2_q[0]);
    state_d = state_q;
    if (reset_any)
    begin
      state_d = 1'b0;
    end
    else if (set_any)
    begin
      state_d = 1'b1;
    end
  end

  // No reset term: the latch powers up unknown
  always_ff @(posedge sys_clk)
  begin
    state_q <= state_d;
  end

  // ****************************************************************
  // Output selection
  // ****************************************************************
  logic pin_o_q;
  logic pin_o_d;
  logic pin_oe_q;
  logic pin_oe_d;
  logic q_q;
  logic qn_q;

  always_comb
  begin
    pin_o_d = port_data;
    if (ctrl_q.latch_enable && ctrl_q.true_output_pin_enable)
    begin
      pin_o_d = state_d;
    end
    else if (ctrl_q.latch_enable && ctrl_q.inverted_output_pin_enable)
    begin
      pin_o_d = ~state_d;
    end
    pin_oe_d = ~port_direction_bit;
  end

  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      pin_o_q <= 1'b0;
      pin_oe_q <= 1'b0;
    end
    else
    begin
      pin_o_q <= pin_o_d;
      pin_oe_q <= pin_oe_d;
    end
  end

  always_ff @(posedge sys_clk)
  begin
    q_q <= state_d;
    qn_q <= ~state_d;
  end

  assign reg_rdata = rdata_q;
  assign latch_output_pin_o = pin_o_q;
  assign latch_output_pin_oe = pin_oe_q;
  assign latch_q = q_q;
  assign latch_qn = qn_q;

endmodule : set_reset_latch_unit

`default_nettype wire

// File: dv/sr_chk.sv
`timescale 1ns/1ps
`default_nettype none
module sr_chk (
  input wire logic sys_clk, rst_n, reg_write, reg_read, port_direction_bit, port_data,
  input wire logic latch_output_pin_o, latch_output_pin_oe, latch_q, latch_qn,
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wdata, reg_rdata
);
  // **********
  // Control shadow
  // **********
  logic [7:0] ctl_q;
  logic [7:0] ctl_d;
  logic io, qr, nr;
  always_comb
  begin
    ctl_d = (reg_write && reg_addr == 4'h0) ? reg_wdata : ctl_q;
    io = !(ctl_q[7] && (ctl_q[3] || ctl_q[2]));
    qr = ctl_q[7] && ctl_q[3];
    nr = ctl_q[7] && !ctl_q[3] && ctl_q[2];
  end
  always_ff @(posedge sys_clk) ctl_q <= rst_n ? ctl_d : 8'h00;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  AST_FW_RESET: assert property (
    reg_write && reg_addr == 4'h0 && reg_wdata[0] |-> ##2 !latch_q) else $error("no reset");
  AST_FW_ZERO: assert property (
    reg_read && reg_addr == 4'h0 |=> reg_rdata[1:0] == 2'b00) else $error("pulse bits");
  AST_STATUS: assert property (
    reg_read && reg_addr == 4'h2 |=> reg_rdata == {7'h00, $past(latch_q)}) else $error("status");
  AST_UNMAP: assert property (
    reg_read && reg_addr > 4'h2 |=> reg_rdata == 8'h00) else $error("unmapped");
  AST_QN_HI: assert property (latch_q |-> !latch_qn) else $error("qn");
  AST_QN_LO: assert property (!latch_q |-> latch_qn) else $error("qn");
  AST_PIN_IO: assert property (
    $past(rst_n) && $past(io) |-> latch_output_pin_o == $past(port_data)) else $error("io");
  AST_PIN_Q: assert property ($past(qr) |-> latch_output_pin_o == latch_q) else $error("q");
  AST_PIN_NQ: assert property ($past(nr) |-> latch_output_pin_o == latch_qn) else $error("nq");
  AST_OE: assert property (
    $past(rst_n) |-> latch_output_pin_oe == !$past(port_direction_bit)) else $error("oe");
endmodule : sr_chk
`default_nettype wire

// File: dv/sr_far_side.sv
`timescale 1ns/1ps
`default_nettype none
module sr_far_side (
  input wire logic sys_clk, latch_output_pin_o, latch_output_pin_oe,
  input wire logic [2:0] level,
  output logic [1:0] comparator_output,
  output logic external_interrupt_pin,
  output wire logic pad
);
  // **********
  // Sources move off the clock edge; the pad has a pull-up
  // **********
  initial {external_interrupt_pin, comparator_output} = 3'h0;
  always @(posedge sys_clk) #7 {external_interrupt_pin, comparator_output} <= level;
  assign pad = latch_output_pin_oe ? latch_output_pin_o : 1'b1;
endmodule : sr_far_side
`default_nettype wire

// File: dv/set_reset_latch_unit_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module set_reset_latch_unit_tb_top;
  logic sys_clk = 1'b0, rst_n = 1'b0, reg_write = 1'b0, reg_read = 1'b0;
  logic port_direction_bit = 1'b1, port_data = 1'b0, q, e;
  logic [3:0] reg_addr = 4'h0;
  logic [7:0] reg_wdata = 8'h00, reg_rdata, c;
  logic [2:0] level = 3'h0;
  logic [1:0] comparator_output;
  logic external_interrupt_pin, latch_output_pin_o, latch_output_pin_oe, latch_q, latch_qn, pad;
  int n_mismatch = 0, samples_checked = 0, cyc = 0, n, i;
  logic [11:0] rows [9] = '{12'h103, 12'h024, 12'h809, 12'h088, 12'h002, 12'h205, 12'h012,
    12'h401, 12'h99A};
  logic [7:0] ctl [6] = '{8'h00, 8'h80, 8'h84, 8'h88, 8'h8C, 8'h0C};
  set_reset_latch_unit i_set_reset_latch_unit (.sys_clk, .rst_n, .reg_addr, .reg_wdata,
    .reg_write, .reg_read, .reg_rdata, .comparator_output, .external_interrupt_pin,
    .port_direction_bit, .port_data, .latch_output_pin_o, .latch_output_pin_oe, .latch_q, .latch_qn);
  sr_far_side i_sr_far_side (.sys_clk, .latch_output_pin_o, .latch_output_pin_oe, .level,
    .comparator_output, .external_interrupt_pin, .pad);
  initial forever #20 sys_clk = ~sys_clk;
  always @(posedge sys_clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      n_mismatch++;
      print_verdict();
    end
  end
  task check(input logic [15:0] got, exp);
    samples_checked++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask : check
  task wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    reg_write <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge sys_clk);
    reg_write <= 1'b0;
  endtask : wr
  task rd(input logic [3:0] a, input logic [7:0] e);
    @(posedge sys_clk);
    reg_read <= 1'b1;
    reg_addr <= a;
    @(posedge sys_clk);
    reg_read <= 1'b0;
    #1 check(reg_rdata, e);
  endtask : rd
  // Cycles between two rising edges of the latch
  task per(output int m);
    int k;
    logic p;
    m = 0;
    k = 0;
    p = 1'b1;
    while (k < 2)
    begin
      @(posedge sys_clk);
      if (latch_q === 1'b1 && p === 1'b0) k++;
      if (k == 1) m++;
      p = latch_q;
    end
  endtask : per
  task print_verdict;
    $display("mismatches %0d checks %0d", n_mismatch, samples_checked);
    if (n_mismatch == 0 && samples_checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : print_verdict
  initial
  begin
    repeat (20) @(posedge sys_clk);
    rst_n <= 1'b1;
    #1 check(latch_output_pin_oe, 0);
    rd(4'h0, 8'h00);
    rd(4'h1, 8'h00);
    rd(4'h9, 8'h00);
    wr(4'h0, 8'h01);
    for (i = 0; i < 9; i++)
    begin
      wr(4'h1, rows[i][11:4]);
      rd(4'h1, rows[i][11:4]);
      level <= rows[i][3:1];
      repeat (5) @(posedge sys_clk);
      rd(4'h2, {7'h00, rows[i][0]});
      level <= 3'h0;
      repeat (5) @(posedge sys_clk);
    end
    wr(4'h1, 8'h84);
    level <= 3'h4;
    for (i = 0; i < 8; i++)
    begin
      wr(4'h0, {1'b0, i[2:0], 4'h0});
      per(n);
      per(n);
      check(n[15:0], 16'h0004 << i);
    end
    level <= 3'h0;
    wr(4'h1, 8'h00);
    port_direction_bit <= 1'b0;
    port_data <= 1'b1;
    for (i = 0; i < 12; i++)
    begin
      c = ctl[i / 2];
      q = i[0];
      // Port data opposes the routed value so routing is visible
      e = c[3] ? q : !q;
      @(posedge sys_clk);
      port_data <= !e;
      wr(4'h0, c | (q ? 8'h02 : 8'h01));
      rd(4'h0, c);
      check(pad, (c[7] && (c[3] || c[2])) ? e : !e);
    end
    @(posedge sys_clk);
    port_direction_bit <= 1'b1;
    repeat (2) @(posedge sys_clk);
    #1 check(pad, 1);
    check(latch_output_pin_oe, 0);
    // Reset in mid run clears the registers
    @(posedge sys_clk);
    rst_n <= 1'b0;
    repeat (3) @(posedge sys_clk);
    rst_n <= 1'b1;
    rd(4'h0, 8'h00);
    rd(4'h1, 8'h00);
    print_verdict();
  end
endmodule : set_reset_latch_unit_tb_top
bind set_reset_latch_unit sr_chk i_sr_chk (.sys_clk, .rst_n, .reg_write, .reg_read,
  .port_direction_bit, .port_data, .latch_output_pin_o, .latch_output_pin_oe, .latch_q,
  .latch_qn, .reg_addr, .reg_wdata, .reg_rdata);
`default_nettype wire
